// file: art_cpu_model.sv
// partner: cpu-side avalon-mm master, one byte per word
`timescale 1ns/100ps
`default_nettype none
module art_cpu_model (
  input  wire logic                        core_clk,
  output logic      [art_pkg::ADDR_W-1:0]  avs_address,
  output logic                             avs_read,
  output logic                             avs_write,
  output logic      [art_pkg::DATA_W-1:0]  avs_writedata,
  output logic      [3:0]                  avs_byteenable,
  input  wire logic [art_pkg::DATA_W-1:0]  avs_readdata,
  input  wire logic                        avs_waitrequest
);
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'h0;
  end
  // request held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [3:0] idx,
                      input logic [7:0] wd, input logic [3:0] be,
                      output logic [7:0] rd);
    @(posedge core_clk);
    avs_address <= idx;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h00_0000, wd};
    avs_byteenable <= be;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~avs_writedata;
  endtask : xfer
endmodule : art_cpu_model
`default_nettype wire

// file: art_monitor.sv
// checker: port-level properties of the auto-reload timer
`timescale 1ns/100ps
`default_nettype none
module art_monitor #(
  parameter int unsigned CH_N  = 4,
  parameter int unsigned CAP_N = 2
) (
  input wire logic                        core_clk,
  input wire logic                        reset,
  input wire logic [art_pkg::ADDR_W-1:0]  avs_address,
  input wire logic                        avs_read,
  input wire logic                        avs_write,
  input wire logic [art_pkg::DATA_W-1:0]  avs_readdata,
  input wire logic                        avs_waitrequest,
  input wire logic                        halt_mode,
  input wire logic [CH_N-1:0]             pwm_out,
  input wire logic [CH_N-1:0]             pwm_out_oe,
  input wire logic                        overflow_irq,
  input wire logic [CAP_N-1:0]            capture_irq,
  input wire logic                        wake_request
);
  wire acc   = (avs_read || avs_write) && !avs_waitrequest;
  wire rd_ok = avs_read && !avs_waitrequest;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bad wait cycle");
  property p_oe_gate;
    (pwm_out & ~pwm_out_oe) == '0;
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("pwm while off");
  property p_wake;
    wake_request == |capture_irq;
  endproperty
  a_wake: assert property (p_wake) else $error("wake mismatch");
  property p_frl_zero;
    rd_ok && avs_address == art_pkg::IDX_CSR |-> !avs_readdata[2];
  endproperty
  a_frl_zero: assert property (p_frl_zero) else $error("reload bit read");
  property p_ovf_irq;
    rd_ok && avs_address == art_pkg::IDX_CSR && avs_readdata[0]
      && avs_readdata[1] |-> overflow_irq;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("no overflow irq");
  property p_ovf_hold;
    overflow_irq && !(acc && avs_address == art_pkg::IDX_CSR)
      |=> overflow_irq;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("irq dropped");
  property p_cap_hold;
    capture_irq[0] && !(acc && (avs_address == art_pkg::IDX_CAP1
      || avs_address == art_pkg::IDX_CAPCSR)) |=> capture_irq[0];
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capture irq lost");
  property p_cap_irq;
    rd_ok && avs_address == art_pkg::IDX_CAPCSR
      |-> (avs_readdata[1:0] & avs_readdata[3:2] & ~capture_irq) == '0;
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("capture irq low");
  property p_halt;
    halt_mode && !(avs_write && !avs_waitrequest) |=> $stable(pwm_out);
  endproperty
  a_halt: assert property (p_halt) else $error("pwm moved in halt");
endmodule : art_monitor
`default_nettype wire

// file: art_pkg.sv
// package: register map, field positions and types for the auto-reload timer
package art_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  // register word indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_DUTY3   = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_DUTY2   = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_DUTY1   = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_DUTY0   = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_PWMCTL  = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_CSR     = 4'h5;
  localparam logic [ADDR_W-1:0] IDX_CAR     = 4'h6;
  localparam logic [ADDR_W-1:0] IDX_ARR     = 4'h7;
  localparam logic [ADDR_W-1:0] IDX_CAPCSR  = 4'h8;
  localparam logic [ADDR_W-1:0] IDX_CAP1    = 4'h9;
  localparam logic [ADDR_W-1:0] IDX_CAP2    = 4'hA;
  // control/status fields
  localparam int unsigned CSR_SRC  = 7;
  localparam int unsigned CSR_PS_H = 6;
  localparam int unsigned CSR_PS_L = 4;
  localparam int unsigned CSR_RUN  = 3;
  localparam int unsigned CSR_FRL  = 2;
  localparam int unsigned CSR_OIE  = 1;
  localparam int unsigned CSR_OVF  = 0;
  // capture control fields
  localparam int unsigned CAP_ES_L  = 4;
  localparam int unsigned CAP_IE_L  = 2;
  localparam int unsigned CAP_FL_L  = 0;
  localparam int unsigned PWM_OE_L  = 4;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [7:0]  CNT_MAX   = 8'hFF;
  localparam logic [6:0]  PRE_ZERO  = 7'h00;

  typedef struct packed {
    logic       src_ext;
    logic [2:0] prescale;
    logic       run;
    logic       overflow_irq_enable;
  } csr_s;

  typedef struct packed {
    logic [1:0] edge_rise;
    logic [1:0] irq_en;
  } capctl_s;
endpackage : art_pkg

// file: pwm_auto_reload_timer.sv
// pwm auto-reload timer with avalon-mm register slave
// Notes on behaviour
// - counter increments once per prescaler output tick while running
// - overflow reloads counter from reload value; prescaler untouched
// - prescaler divides input by two to the power prescale_select
// - clock_source_select bit 7 picks cpu clock (0) or external clock (1)
// - counter_run bit 3 clear freezes prescaler and counter
// - reset clears counter and prescaler and selects cpu clock
// - counter access read gives live count; write loads it, clears prescaler
// - force_reload bit 2 reads zero; writing one loads reload, clears prescaler
// - four compare shadows copy duty registers at each overflow
// - pwm_pin_enable bit per channel enables its push-pull pwm pin
// - overflow drives inverse of polarity level; compare match restores polarity level
// - all channels share period of 256 minus reload value counts
// - pwm generation halts while chip is in halt mode
// - overflow sets flag; interrupt asserted while flag and enable set
// - overflow flag at bit 0 cleared by reading control/status
// - external clock counts 256 minus reload events per overflow when prescale_select is 0
// - selected capture edge latches count, sets flag, may interrupt
// - capture register locked after capture until software reads it
// - capture interrupt stays high while flag and enable both set
// - capture edges act as external interrupts and wake from halt
// - polarity 0: high at or below compare, low above; 1 inverts
// - capture edge select 0 falling, 1 rising
//
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module pwm_auto_reload_timer #(
  parameter int unsigned CH_N  = 4,
  parameter int unsigned CAP_N = 2
) (
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire logic [art_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [art_pkg::DATA_W-1:0]  avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [art_pkg::DATA_W-1:0]  avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        external_event_clock,
  input  wire logic [CAP_N-1:0]            capture_pin,
  input  wire logic                        halt_mode,
  output logic      [CH_N-1:0]             pwm_out,
  output logic      [CH_N-1:0]             pwm_out_oe,
  output logic                             overflow_irq,
  output logic      [CAP_N-1:0]            capture_irq,
  output logic                             wake_request
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic              ack_q;
  logic              wr_acc;
  logic              rd_acc;
  art_pkg::csr_s     csr_q;
  art_pkg::capctl_s  capctl_q;
  logic [7:0]        reload_q;
  logic [7:0]        pwm_ctl_q;
  logic [7:0]        duty_q [CH_N];
  logic [7:0]        shadow_q [CH_N];
  logic [7:0]        count_q;
  logic [6:0]        pre_q;
  logic              ovf_q;
  logic [CAP_N-1:0]  cap_flag_q;
  logic [7:0]        cap_val_q [CAP_N];
  logic [CH_N-1:0]   pwm_lvl_q;
  logic [7:0]        wbyte;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  // one wait state: answer on the edge after the request is seen.
  // ack_q drops on the edge that completes the transfer, so a request
  // held beyond it starts a fresh access and repeats a write
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  assign avs_waitrequest = !ack_q;

  // register data sits in byte lane 0; a write without it is ignored
  assign wr_acc = avs_write && ack_q && avs_byteenable[0];
  assign rd_acc = avs_read && ack_q;
  assign wbyte  = avs_writedata[7:0];

  // word select for the addressed register
  function automatic logic hit(input logic [art_pkg::ADDR_W-1:0] idx);
    hit = (avs_address == idx);
  endfunction : hit

  // duty words are laid out from channel 3 down to channel 0
  function automatic logic [art_pkg::ADDR_W-1:0] duty_idx(input int ch);
    duty_idx = art_pkg::IDX_DUTY0 - art_pkg::ADDR_W'(ch);
  endfunction : duty_idx

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      csr_q     <= '0;
      capctl_q  <= '0;
      reload_q  <= art_pkg::BYTE_ZERO;
      pwm_ctl_q <= art_pkg::BYTE_ZERO;
    end else if (wr_acc) begin
      if (hit(art_pkg::IDX_CSR)) begin
        // force_reload acts as a strobe and is not stored
        csr_q.src_ext  <= wbyte[art_pkg::CSR_SRC];
        csr_q.prescale <= wbyte[art_pkg::CSR_PS_H:art_pkg::CSR_PS_L];
        csr_q.run      <= wbyte[art_pkg::CSR_RUN];
        csr_q.overflow_irq_enable      <= wbyte[art_pkg::CSR_OIE];
      end
      if (hit(art_pkg::IDX_CAPCSR)) begin
        // capture flags are read-only; a write cannot set them
        capctl_q.edge_rise <= wbyte[art_pkg::CAP_ES_L +: CAP_N];
        capctl_q.irq_en    <= wbyte[art_pkg::CAP_IE_L +: CAP_N];
      end
      if (hit(art_pkg::IDX_ARR)) begin
        reload_q <= wbyte;
      end
      if (hit(art_pkg::IDX_PWMCTL)) begin
        pwm_ctl_q <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // duty registers, software side of the compare shadows
  // ----------------------------------------------------------------
  for (genvar c = 0; c < CH_N; c++) begin : g_duty
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        duty_q[c] <= art_pkg::BYTE_ZERO;
      end else if (wr_acc && hit(duty_idx(c))) begin
        duty_q[c] <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // input clock selection and prescaler
  // ----------------------------------------------------------------
  logic ext_q;
  logic ext_rise;
  logic in_tick;
  logic tick;
  logic [7:0] pre_ext;
  logic [7:0] pre_next;
  logic load_car;
  logic force_rl;
  logic ovf_evt;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= external_event_clock;
    end
  end
  // ext_q resets low, the idle level of the event pin, so no count
  // is made up at reset; one event needs one core cycle at each level
  assign ext_rise = external_event_clock && !ext_q;

  // halt freezes the input side, which stops counter and pwm together
  assign in_tick  = csr_q.run && !halt_mode &&
                    (csr_q.src_ext ? ext_rise : 1'b1);
  assign pre_ext  = {1'b0, pre_q};
  assign pre_next = pre_ext + 8'h01;

  // tap n fires when bit n of the prescaler changes, one tick for every
  // two to the n input ticks; the top tap reads the carry out of bit 6
  always_comb begin
    tick = 1'b0;
    if (in_tick) begin
      if (csr_q.prescale == 3'h0) begin
        tick = 1'b1;
      end else begin
        tick = pre_next[csr_q.prescale] != pre_ext[csr_q.prescale];
      end
    end
  end

  // a counter write or forced reload takes the edge from a tick, and
  // masks the overflow so neither flag, shadow nor pwm high level is set on a software load
  assign load_car = wr_acc && hit(art_pkg::IDX_CAR);
  assign force_rl = wr_acc && hit(art_pkg::IDX_CSR) &&
                    wbyte[art_pkg::CSR_FRL];
  assign ovf_evt  = tick && (count_q == art_pkg::CNT_MAX) && !load_car &&
                    !force_rl;

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pre_q <= art_pkg::PRE_ZERO;
    end else if (load_car || force_rl) begin
      pre_q <= art_pkg::PRE_ZERO;
    end else if (in_tick) begin
      pre_q <= pre_next[6:0];
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // software loads win over the overflow reload, which wins over a count
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count_q <= art_pkg::BYTE_ZERO;
    end else if (load_car) begin
      count_q <= wbyte;
    end else if (force_rl) begin
      count_q <= reload_q;
    end else if (ovf_evt) begin
      count_q <= reload_q;
    end else if (tick) begin
      count_q <= count_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // pwm channels
  // ----------------------------------------------------------------
  for (genvar c = 0; c < CH_N; c++) begin : g_pwm
    // the shadow moves only at overflow, so a duty write never cuts
    // the running period short
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        shadow_q[c] <= art_pkg::BYTE_ZERO;
      end else if (ovf_evt) begin
        shadow_q[c] <= duty_q[c];
      end
    end

    // raw level: high at overflow, low once count passes compare
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        pwm_lvl_q[c] <= 1'b1;
      end else if (ovf_evt) begin
        pwm_lvl_q[c] <= 1'b1;
      end else if (tick && count_q == shadow_q[c]) begin
        pwm_lvl_q[c] <= 1'b0;
      end
    end

    // polarity acts after the flop, so a change shows at once;
    // a disabled channel drives low
    assign pwm_out[c]    = pwm_ctl_q[art_pkg::PWM_OE_L + c] &
                           (pwm_lvl_q[c] ^ pwm_ctl_q[c]);
    assign pwm_out_oe[c] = pwm_ctl_q[art_pkg::PWM_OE_L + c];
  end

  // ----------------------------------------------------------------
  // overflow flag
  // ----------------------------------------------------------------
  // an overflow meeting a status read leaves the flag set
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ovf_q <= 1'b0;
    end else if (ovf_evt) begin
      ovf_q <= 1'b1;
    end else if (rd_acc && hit(art_pkg::IDX_CSR)) begin
      ovf_q <= 1'b0;
    end
  end
  assign overflow_irq = ovf_q && csr_q.overflow_irq_enable;

  // ----------------------------------------------------------------
  // input capture
  // ----------------------------------------------------------------
  // previous pin levels for edge detection; they reset low and rising
  // capture is off after reset, so a pin high at reset gives no edge
  logic [CAP_N-1:0] cap_pin_q;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cap_pin_q <= '0;
    end else begin
      cap_pin_q <= capture_pin;
    end
  end

  for (genvar k = 0; k < CAP_N; k++) begin : g_cap
    logic cap_edge;
    logic cap_rd;
    assign cap_edge = capctl_q.edge_rise[k] ?
                      (capture_pin[k] && !cap_pin_q[k]) :
                      (!capture_pin[k] && cap_pin_q[k]);
    // a read clears the flag; an edge on the same cycle as the read is
    // lost, since the register is still locked then
    assign cap_rd = rd_acc &&
                    hit(art_pkg::IDX_CAP1 + art_pkg::ADDR_W'(k));
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        cap_val_q[k] <= art_pkg::BYTE_ZERO;
      end else if (cap_edge && !cap_flag_q[k]) begin
        cap_val_q[k] <= count_q;
      end
    end
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        cap_flag_q[k] <= 1'b0;
      end else if (cap_edge && !cap_flag_q[k]) begin
        cap_flag_q[k] <= 1'b1;
      end else if (cap_rd) begin
        cap_flag_q[k] <= 1'b0;
      end
    end
    assign capture_irq[k] = cap_flag_q[k] && capctl_q.irq_en[k];
  end

  // ----------------------------------------------------------------
  // wake request
  // ----------------------------------------------------------------
  assign wake_request = |capture_irq;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // reserved, write-only and unmapped bits all read as zero
  logic [7:0] rbyte;
  always_comb begin
    rbyte = art_pkg::BYTE_ZERO;
    for (int c = 0; c < CH_N; c++) begin
      if (hit(duty_idx(c))) begin
        rbyte = duty_q[c];
      end
    end
    if (hit(art_pkg::IDX_PWMCTL)) begin
      rbyte = pwm_ctl_q;
    end
    if (hit(art_pkg::IDX_CSR)) begin
      rbyte = {csr_q.src_ext, csr_q.prescale, csr_q.run, 1'b0,
               csr_q.overflow_irq_enable, ovf_q};
    end
    if (hit(art_pkg::IDX_CAR)) begin
      rbyte = count_q;
    end
    if (hit(art_pkg::IDX_ARR)) begin
      rbyte = reload_q;
    end
    if (hit(art_pkg::IDX_CAPCSR)) begin
      rbyte = {2'b00, capctl_q.edge_rise, capctl_q.irq_en, cap_flag_q};
    end
    for (int k = 0; k < CAP_N; k++) begin
      if (hit(art_pkg::IDX_CAP1 + art_pkg::ADDR_W'(k))) begin
        rbyte = cap_val_q[k];
      end
    end
  end

  // ----------------------------------------------------------------
  // read data register
  // ----------------------------------------------------------------
  // taken on the request edge, it stands through the answer cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= {24'h00_0000, rbyte};
    end
  end

endmodule : pwm_auto_reload_timer
`default_nettype wire

// file: tb.sv
// testbench: registers, counter, pwm and capture of the timer
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [3:0] idx;
    logic [7:0] wd;
    logic [3:0] be;
    logic [7:0] ex;
  } row_s;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  avs_address, avs_byteenable;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic        external_event_clock = 1'b0;
  logic [1:0]  capture_pin = 2'b10;
  logic        halt_mode = 1'b0;
  logic [3:0]  pwm_out, pwm_out_oe;
  logic        overflow_irq, wake_request;
  logic [1:0]  capture_irq;
  logic [7:0]  r;
  int          fail_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          hi;
  row_s rows [9] = '{
    '{art_pkg::IDX_DUTY0, 8'hC3, 4'hF, 8'hC3},
    '{art_pkg::IDX_PWMCTL, 8'hA5, 4'hF, 8'hA5},
    '{art_pkg::IDX_ARR, 8'h3C, 4'hF, 8'h3C},
    '{art_pkg::IDX_ARR, 8'h99, 4'h0, 8'h3C},
    '{art_pkg::IDX_CSR, 8'h06, 4'hF, 8'h02},
    '{art_pkg::IDX_CAR, 8'h77, 4'hF, 8'h77},
    '{art_pkg::IDX_CAPCSR, 8'hFF, 4'hF, 8'h3C},
    '{art_pkg::IDX_CAP1, 8'h12, 4'hF, 8'h00},
    '{4'hF, 8'h77, 4'hF, 8'h00}};
  always #50 core_clk = ~core_clk;
  pwm_auto_reload_timer u_dut (
    .core_clk(core_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .external_event_clock(external_event_clock),
    .capture_pin(capture_pin), .halt_mode(halt_mode), .pwm_out(pwm_out),
    .pwm_out_oe(pwm_out_oe), .overflow_irq(overflow_irq),
    .capture_irq(capture_irq), .wake_request(wake_request));
  art_cpu_model u_cpu (
    .core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      $display("Error %0t: got %h expected %h", $time, s, e);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_cpu.xfer(1'b1, a, d, 4'hF, r);
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    u_cpu.xfer(1'b0, a, 8'h00, 4'hF, r);
    chk(r, e);
  endtask : rdc
  task automatic tally_and_finish();
    if (fail_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    chk({4'h0, pwm_out_oe}, 8'h00);
    for (int i = 0; i < 11; i++) rdc(4'(i), 8'h00);
    foreach (rows[i]) begin
      u_cpu.xfer(1'b1, rows[i].idx, rows[i].wd, rows[i].be, r);
      rdc(rows[i].idx, rows[i].ex);
    end
    wr(art_pkg::IDX_CSR, 8'h04);
    rdc(art_pkg::IDX_CAR, 8'h3C);
    for (int p = 0; p < 8; p++) begin
      wr(art_pkg::IDX_CAR, 8'h00);
      wr(art_pkg::IDX_CSR, {1'b0, 3'(p), 4'h8});
      repeat ((7 << p) / 2 - 3) @(posedge core_clk);
      wr(art_pkg::IDX_CSR, 8'h00);
      rdc(art_pkg::IDX_CAR, 8'h03);
    end
    wr(art_pkg::IDX_ARR, 8'hFC);
    wr(art_pkg::IDX_CAR, 8'hFE);
    wr(art_pkg::IDX_CSR, 8'h0A);
    wr(art_pkg::IDX_CSR, 8'h02);
    @(negedge core_clk);
    chk({7'h00, overflow_irq}, 8'h01);
    rdc(art_pkg::IDX_CAR, 8'hFD);
    rdc(art_pkg::IDX_CSR, 8'h03);
    rdc(art_pkg::IDX_CSR, 8'h02);
    @(negedge core_clk);
    chk({7'h00, overflow_irq}, 8'h00);
    wr(art_pkg::IDX_DUTY0, 8'hFE);
    wr(art_pkg::IDX_PWMCTL, 8'h10);
    wr(art_pkg::IDX_CSR, 8'h08);
    for (int k = 0; k < 2; k++) begin
      repeat (8) @(posedge core_clk);
      hi = 0;
      repeat (16) begin
        @(posedge core_clk);
        hi += int'(pwm_out[0]);
      end
      chk(hi[7:0], k ? 8'h04 : 8'h0C);
      wr(art_pkg::IDX_PWMCTL, 8'h11);
    end
    chk({4'h0, pwm_out_oe}, 8'h01);
    chk({4'h0, pwm_out & 4'hE}, 8'h00);
    halt_mode <= 1'b1;
    repeat (20) @(posedge core_clk);
    halt_mode <= 1'b0;
    wr(art_pkg::IDX_CSR, 8'h00);
    rdc(art_pkg::IDX_CSR, 8'h01);
    wr(art_pkg::IDX_ARR, 8'hFD);
    wr(art_pkg::IDX_CAR, 8'hFD);
    wr(art_pkg::IDX_CSR, 8'h88);
    for (int k = 0; k < 6; k++) begin
      repeat (4) @(posedge core_clk);
      external_event_clock <= ~external_event_clock;
      if (k == 3) rdc(art_pkg::IDX_CAR, 8'hFF);
      if (k == 3) rdc(art_pkg::IDX_CSR, 8'h88);
    end
    repeat (4) @(posedge core_clk);
    rdc(art_pkg::IDX_CSR, 8'h89);
    wr(art_pkg::IDX_CSR, 8'h00);
    rdc(art_pkg::IDX_CAR, 8'hFD);
    wr(art_pkg::IDX_CAR, 8'h40);
    wr(art_pkg::IDX_CAPCSR, 8'h14);
    capture_pin[0] <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk({6'h00, capture_irq}, 8'h01);
    chk({7'h00, wake_request}, 8'h01);
    wr(art_pkg::IDX_CAR, 8'h50);
    capture_pin <= 2'b00;
    repeat (4) @(posedge core_clk);
    capture_pin[0] <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk({6'h00, capture_irq}, 8'h01);
    rdc(art_pkg::IDX_CAP1, 8'h40);
    @(negedge core_clk);
    chk({6'h00, capture_irq}, 8'h00);
    rdc(art_pkg::IDX_CAPCSR, 8'h16);
    rdc(art_pkg::IDX_CAP2, 8'h50);
    tally_and_finish();
  end
endmodule : tb
bind pwm_auto_reload_timer art_monitor #(.CH_N(CH_N), .CAP_N(CAP_N)) u_mon (
  .core_clk(core_clk), .reset(reset), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .halt_mode(halt_mode),
  .pwm_out(pwm_out), .pwm_out_oe(pwm_out_oe), .overflow_irq(overflow_irq),
  .capture_irq(capture_irq), .wake_request(wake_request));
`default_nettype wire
